// ==== include/fan_pkg.sv ====
// Purpose: Shared constants and types for the fan drive with lock guard.
// Assumes: 100 MHz clk; analog levels are carried as millivolt codes.
// Notes:   Levels are scaled for a 12 V supply.
// How it works
// - H+ above H- makes leg B active
// - Ramp versus demand forms drive pulses, 25 kHz
// - Ramp swings 0.16 to 0.3 of supply
// - Demand 3.6V..1.95V maps to 0..100% duty
// - Demand at ground gives full duty
// - Effective demand never exceeds minimum-speed level, or the tied level when the minimum input is tied
// - Minimum level above 0.28 supply holds lowest speed
// - Lock timer counts whenever motor is driven
// - Hall transition restarts lock timer, except during the off period
// - Window expiry disables both legs, enters lock
// - Lock state leaves motor undriven for off period
// - Off period lasts ten detect windows
// - Off period end resumes drive, fresh window
// - No transition in restart window repeats off
// - Transition during restart returns to running
// - Tach output pulls low following Hall polarity
// - Lock alarm released while locked
// - Lock alarm pulls low while rotating
// - Demand below ramp low gives full speed
// - Tied minimum input gives 10% minimum duty
package fan_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 10;
    localparam int RAMP_FREQ_KHZ      = 25;
    localparam int RAMP_PERIOD_CYCLES =
        1000000 / (RAMP_FREQ_KHZ * CLK_PERIOD_NS);
    localparam int RAMP_HALF_CYCLES   = RAMP_PERIOD_CYCLES / 2;
    localparam int TICK_NS            = 1000;
    localparam int TICK_CYCLES        = TICK_NS / CLK_PERIOD_NS;
    localparam int DETECT_TICKS       = 470000;
    localparam int OFF_RATIO          = 10;

    // ------------------------------------------------------------
    // Levels in millivolts
    // ------------------------------------------------------------
    localparam int           LVL_W           = 12;
    localparam logic [11:0]  RAMP_LOW_MV     = 12'h79E;
    localparam logic [11:0]  RAMP_HIGH_MV    = 12'hE10;
    localparam logic [11:0]  RAMP_SPAN_MV    = 12'h672;
    localparam logic [11:0]  LOWEST_SPEED_MV = 12'hD20;
    localparam logic [11:0]  MIN_TIED_MV     = 12'hD6B;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam int          WIN_W          = 24;
    localparam int          TMR_W          = 28;
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  WINDOW_OFS     = 8'h04;
    localparam logic [7:0]  STATUS_OFS     = 8'h08;
    localparam int          CTRL_DEMAND_LSB = 0;
    localparam int          CTRL_MIN_LSB    = 16;
    localparam int          CTRL_TIED_BIT   = 31;
    localparam int          STAT_POL_BIT    = 2;
    localparam int          STAT_TACH_BIT   = 3;
    localparam int          STAT_ALARM_BIT  = 4;
    localparam int          STAT_COUNT_LSB  = 8;
    localparam logic [11:0] DEMAND_RST     = 12'h000;
    localparam logic [11:0] MIN_RST        = 12'h000;
    localparam logic        TIED_RST       = 1'b1;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_OFF     = 2'b01,
        ST_RESTART = 2'b10
    } lockState_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apbReq_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apbRsp_t;

endpackage : fan_pkg

// ==== verilog/ramp_gen.sv ====
// Purpose: Triangular ramp between the low and high levels.
// Assumes: One clock; the ramp is a millivolt code.
// Notes:   A fractional accumulator keeps the exact period.
`timescale 1ns/1ps
module ramp_gen #(
    parameter int HALF_CYCLES = fan_pkg::RAMP_HALF_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    output logic      [11:0] level
);

    typedef struct packed {
        logic [11:0] level;
        logic [15:0] acc;
        logic        down;
    } rampState_t;

    localparam logic [15:0] HALF = 16'(HALF_CYCLES);

    rampState_t r;
    rampState_t next_r;

    // ------------------------------------------------------------
    // Ramp stepping
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] sum;
        sum    = r.acc + 16'(fan_pkg::RAMP_SPAN_MV);
        next_r = r;
        // Span below half period, so at most one step per cycle
        if (sum >= HALF) begin
            next_r.acc = sum - HALF;
            if (r.down) begin
                next_r.level = r.level - 12'h001;
                if (r.level == fan_pkg::RAMP_LOW_MV + 12'h001) begin
                    next_r.down = 1'b0;
                end
            end else begin
                next_r.level = r.level + 12'h001;
                if (r.level == fan_pkg::RAMP_HIGH_MV - 12'h001) begin
                    next_r.down = 1'b1;
                end
            end
        end else begin
            next_r.acc = sum;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{level: fan_pkg::RAMP_LOW_MV, acc: 16'h0000,
                   down: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign level = r.level;

endmodule : ramp_gen

// ==== verilog/fan_lock_guard.sv ====
// Purpose: Single-phase fan drive with duty control and lock guard.
// Assumes: Hall and tach pins are asynchronous; APB on clk.
// Notes:   Demand and minimum levels are set over APB as mV codes.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module fan_lock_guard #(
    parameter int DETECT_TICKS = fan_pkg::DETECT_TICKS,
    parameter int TICK_CYCLES  = fan_pkg::TICK_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  fan_pkg::apbReq_t     apbReq,
    output fan_pkg::apbRsp_t     apbRsp,
    input  wire logic            hallPlus,
    input  wire logic            hallMinus,
    output logic                 bridgeLegA,
    output logic                 bridgeLegB,
    input  wire logic            tachIn,
    output logic                 tachOut,
    output logic                 tachOutEnN,
    input  wire logic            alarmIn,
    output logic                 alarmOut,
    output logic                 alarmOutEnN
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                 plusSync;
        logic [1:0]                 minusSync;
        logic [1:0]                 tachSync;
        logic [1:0]                 alarmSync;
        logic                       polB;
        fan_pkg::lockState_t        lockState;
        logic [15:0]                tickDiv;
        logic [fan_pkg::TMR_W-1:0]  timer;
        logic [fan_pkg::WIN_W-1:0]  window;
        logic [11:0]                demand;
        logic [11:0]                minLevel;
        logic                       minTied;
        logic [7:0]                 lockCount;
        logic                       legA;
        logic                       legB;
        logic                       tachEnN;
        logic                       alarmEnN;
        fan_pkg::apbRsp_t           rsp;
    } guardState_t;

    guardState_t s;
    guardState_t next_s;
    logic [11:0] rampLevel;

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [fan_pkg::WIN_W-1:0] WINDOW_RST =
        fan_pkg::WIN_W'(DETECT_TICKS);
    localparam logic [3:0] OFF_MULT = 4'(fan_pkg::OFF_RATIO);

    function automatic logic [11:0] lowerOf(input logic [11:0] a,
                                            input logic [11:0] b);
        lowerOf = (a < b) ? a : b;
    endfunction : lowerOf

    ramp_gen #(
        .HALF_CYCLES (fan_pkg::RAMP_HALF_CYCLES)
    ) ramp (
        .clk   (clk),
        .rst   (rst),
        .level (rampLevel)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic                      tick;
        logic                      hallEdge;
        logic                      expired;
        logic                      driveOn;
        logic [11:0]               minEff;
        logic [11:0]               effLevel;
        logic [fan_pkg::TMR_W-1:0] limit;
        logic                      setup;
        logic                      access;
        logic                      mapped;
        tick     = 1'b0;
        hallEdge = 1'b0;
        expired  = 1'b0;
        driveOn  = 1'b0;
        minEff   = 12'h000;
        effLevel = 12'h000;
        limit    = '0;
        setup    = 1'b0;
        access   = 1'b0;
        mapped   = 1'b0;
        next_s   = s;

        // Pins pass two flops before anything reads them
        next_s.plusSync  = {s.plusSync[0], hallPlus};
        next_s.minusSync = {s.minusSync[0], hallMinus};
        next_s.tachSync  = {s.tachSync[0], tachIn};
        next_s.alarmSync = {s.alarmSync[0], alarmIn};

        // Equal inputs keep the last polarity, like input hysteresis
        if (s.plusSync[1] && !s.minusSync[1]) begin
            next_s.polB = 1'b1;
        end else if (!s.plusSync[1] && s.minusSync[1]) begin
            next_s.polB = 1'b0;
        end
        hallEdge = (next_s.polB != s.polB);

        // Common time base for window and off period
        if (s.tickDiv == TICK_LAST) begin
            next_s.tickDiv = 16'h0000;
            tick           = 1'b1;
        end else begin
            next_s.tickDiv = s.tickDiv + 16'h0001;
        end

        if (s.lockState == fan_pkg::ST_OFF) begin
            limit = fan_pkg::TMR_W'(s.window * OFF_MULT);
        end else begin
            limit = fan_pkg::TMR_W'(s.window);
        end
        expired = tick && (s.timer + 1'b1 >= limit);

        // ------------------------------------------------------------
        // Lock guard sequence
        // ------------------------------------------------------------
        case (s.lockState)
            fan_pkg::ST_RUN: begin
                if (hallEdge) begin
                    next_s.timer = '0;
                end else if (expired) begin
                    next_s.timer     = '0;
                    next_s.lockState = fan_pkg::ST_OFF;
                    next_s.lockCount = s.lockCount + 8'h01;
                end else if (tick) begin
                    next_s.timer = s.timer + 1'b1;
                end
            end
            fan_pkg::ST_OFF: begin
                // Hall activity is ignored while the coil is idle
                if (expired) begin
                    next_s.timer     = '0;
                    next_s.lockState = fan_pkg::ST_RESTART;
                end else if (tick) begin
                    next_s.timer = s.timer + 1'b1;
                end
            end
            fan_pkg::ST_RESTART: begin
                if (hallEdge) begin
                    next_s.timer     = '0;
                    next_s.lockState = fan_pkg::ST_RUN;
                end else if (expired) begin
                    next_s.timer     = '0;
                    next_s.lockState = fan_pkg::ST_OFF;
                    next_s.lockCount = s.lockCount + 8'h01;
                end else if (tick) begin
                    next_s.timer = s.timer + 1'b1;
                end
            end
            default: begin
                next_s.timer     = '0;
                next_s.lockState = fan_pkg::ST_RUN;
            end
        endcase

        // ------------------------------------------------------------
        // Duty comparison
        // ------------------------------------------------------------
        if (s.minTied) begin
            minEff = fan_pkg::MIN_TIED_MV;
        end else begin
            minEff = lowerOf(s.minLevel, fan_pkg::LOWEST_SPEED_MV);
        end
        effLevel = lowerOf(s.demand, minEff);
        // Higher level means slower, so ramp above level drives
        if (s.demand == 12'h000) begin
            driveOn = 1'b1;
        end else if (effLevel < fan_pkg::RAMP_LOW_MV) begin
            driveOn = 1'b1;
        end else begin
            driveOn = (rampLevel > effLevel);
        end

        if (next_s.lockState == fan_pkg::ST_OFF) begin
            next_s.legA = 1'b0;
            next_s.legB = 1'b0;
        end else begin
            next_s.legA = driveOn && !next_s.polB;
            next_s.legB = driveOn && next_s.polB;
        end

        next_s.tachEnN  = next_s.polB;
        // Alarm pulls low whenever the state is ST_RUN; reset releases it until the first clock after reset
        next_s.alarmEnN = (next_s.lockState != fan_pkg::ST_RUN);

        // ------------------------------------------------------------
        // APB slave, one wait-free access phase
        // ------------------------------------------------------------
        setup  = apbReq.psel && !apbReq.penable;
        access = apbReq.psel && apbReq.penable && s.rsp.pready;
        mapped = (apbReq.paddr == fan_pkg::CTRL_OFS) ||
                 (apbReq.paddr == fan_pkg::WINDOW_OFS) ||
                 (apbReq.paddr == fan_pkg::STATUS_OFS);
        next_s.rsp.pready  = setup;
        next_s.rsp.pslverr = setup && !mapped;
        if (setup) begin
            case (apbReq.paddr)
                fan_pkg::CTRL_OFS: begin
                    next_s.rsp.prdata = '0;
                    next_s.rsp.prdata[fan_pkg::CTRL_DEMAND_LSB +: 12] =
                        s.demand;
                    next_s.rsp.prdata[fan_pkg::CTRL_MIN_LSB +: 12] =
                        s.minLevel;
                    next_s.rsp.prdata[fan_pkg::CTRL_TIED_BIT] = s.minTied;
                end
                fan_pkg::WINDOW_OFS: begin
                    next_s.rsp.prdata = 32'(s.window);
                end
                fan_pkg::STATUS_OFS: begin
                    next_s.rsp.prdata = '0;
                    next_s.rsp.prdata[1:0] = s.lockState;
                    next_s.rsp.prdata[fan_pkg::STAT_POL_BIT] = s.polB;
                    next_s.rsp.prdata[fan_pkg::STAT_TACH_BIT] =
                        s.tachSync[1];
                    next_s.rsp.prdata[fan_pkg::STAT_ALARM_BIT] =
                        s.alarmSync[1];
                    next_s.rsp.prdata[fan_pkg::STAT_COUNT_LSB +: 8] =
                        s.lockCount;
                end
                default: begin
                    next_s.rsp.prdata = 32'h00000000;
                end
            endcase
        end
        if (access && apbReq.pwrite && mapped) begin
            if (apbReq.paddr == fan_pkg::CTRL_OFS) begin
                next_s.demand =
                    apbReq.pwdata[fan_pkg::CTRL_DEMAND_LSB +: 12];
                next_s.minLevel =
                    apbReq.pwdata[fan_pkg::CTRL_MIN_LSB +: 12];
                next_s.minTied = apbReq.pwdata[fan_pkg::CTRL_TIED_BIT];
            end else if (apbReq.paddr == fan_pkg::WINDOW_OFS) begin
                // Zero would expire every tick, so keep one tick least
                if (apbReq.pwdata[fan_pkg::WIN_W-1:0] == '0) begin
                    next_s.window = fan_pkg::WIN_W'(1);
                end else begin
                    next_s.window = apbReq.pwdata[fan_pkg::WIN_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s           <= '0;
            s.lockState <= fan_pkg::ST_RUN;
            s.window    <= WINDOW_RST;
            s.demand    <= fan_pkg::DEMAND_RST;
            s.minLevel  <= fan_pkg::MIN_RST;
            s.minTied   <= fan_pkg::TIED_RST;
            s.tachEnN   <= 1'b1;
            s.alarmEnN  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign apbRsp      = s.rsp;
    assign bridgeLegA  = s.legA;
    assign bridgeLegB  = s.legB;
    assign tachOut     = 1'b0;
    assign tachOutEnN  = s.tachEnN;
    assign alarmOut    = 1'b0;
    assign alarmOutEnN = s.alarmEnN;

endmodule : fan_lock_guard

// ==== verif/fan_lock_guard_asserts.sv ====
// Purpose: Port-level checks for the fan drive with lock guard.
// Assumes: Bound to each fan_lock_guard; one clock, async reset.
// Notes:   Only outputs driven by the design are judged.
`timescale 1ns/1ps
module fan_lock_guard_asserts #(
    parameter int DETECT_TICKS = fan_pkg::DETECT_TICKS,
    parameter int TICK_CYCLES  = fan_pkg::TICK_CYCLES
) (
    input wire logic        clk,
    input wire logic        rst,
    input fan_pkg::apbReq_t apbReq,
    input fan_pkg::apbRsp_t apbRsp,
    input wire logic        bridgeLegA,
    input wire logic        bridgeLegB,
    input wire logic        tachOut,
    input wire logic        tachOutEnN,
    input wire logic        alarmOut,
    input wire logic        alarmOutEnN
);
    // ------------------------------------------------------------
    // Helper logic and properties
    // ------------------------------------------------------------
    localparam int WIN = DETECT_TICKS * TICK_CYCLES;
    logic        prevPol;
    int unsigned sinceHall;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Lags the design's timer restart on a transition by one edge, so the bound below has slack
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevPol   <= 1'b1;
            sinceHall <= 0;
        end else begin
            prevPol   <= tachOutEnN;
            sinceHall <= (tachOutEnN != prevPol) ? 0 : sinceHall + 1;
        end
    end

    a_legs_exclusive:
        assert property (!(bridgeLegA && bridgeLegB))
        else $error("Both bridge legs driven at once");
    a_tach_leg_a:
        assert property (bridgeLegA |-> !tachOutEnN)
        else $error("Tach released while leg A drives");
    a_tach_leg_b:
        assert property (bridgeLegB |-> tachOutEnN)
        else $error("Tach pulled low while leg B drives");
    a_pins_sink_only:
        assert property (tachOut == 1'b0 && alarmOut == 1'b0)
        else $error("Open-collector data not low");
    a_lock_legs_off:
        assert property ($rose(alarmOutEnN) |->
                         (!bridgeLegA && !bridgeLegB)[*8])
        else $error("Legs driven right after lock entry");
    a_lock_not_early:
        assert property ($rose(alarmOutEnN) |->
                         sinceHall >= WIN - TICK_CYCLES - 4)
        else $error("Lock entered before the detect window ran out");
    a_ready_after_setup:
        assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
        else $error("No ready in the access cycle");
    a_ready_single:
        assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("Ready held longer than one cycle");
    a_err_needs_ready:
        assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("Slave error without ready");

    c_lock_entry: cover property ($rose(alarmOutEnN));
    c_back_to_run: cover property ($fell(alarmOutEnN));
    c_slave_error: cover property (apbRsp.pslverr);
endmodule : fan_lock_guard_asserts

bind fan_lock_guard fan_lock_guard_asserts #(
    .DETECT_TICKS(DETECT_TICKS),
    .TICK_CYCLES (TICK_CYCLES)
) fan_lock_guard_asserts_inst (
    .clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .bridgeLegA(bridgeLegA), .bridgeLegB(bridgeLegB),
    .tachOut(tachOut), .tachOutEnN(tachOutEnN),
    .alarmOut(alarmOut), .alarmOutEnN(alarmOutEnN)
);

// ==== verif/fan_partner.sv ====
// Purpose: Hall sensor and pulled-up host wires around the fan drive.
// Assumes: Hall edges come from spinning or a one-cycle kick.
// Notes:   No Hall bounce; the sensor outputs are complementary.
`timescale 1ns/1ps
module fan_partner (
    input  wire logic       clk,
    input  wire logic       spin,
    input  wire logic       kick,
    input  wire logic [7:0] halfPer,
    input  wire logic       tachOut,
    input  wire logic       tachOutEnN,
    input  wire logic       alarmOut,
    input  wire logic       alarmOutEnN,
    output logic            hallPlus,
    output logic            hallMinus,
    output logic            tachWire,
    output logic            alarmWire
);
    // ------------------------------------------------------------
    // Rotor and wires
    // ------------------------------------------------------------
    logic       hallState = 1'b0;
    logic [7:0] cnt       = 8'h00;

    always @(posedge clk) begin
        if (kick || (spin && cnt >= halfPer)) begin
            hallState <= ~hallState;
            cnt       <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    assign hallPlus  = hallState;
    assign hallMinus = ~hallState;
    // Host pull-ups: a released wire reads high, never a stale value
    assign tachWire  = tachOutEnN ? 1'b1 : tachOut;
    assign alarmWire = alarmOutEnN ? 1'b1 : alarmOut;
endmodule : fan_partner

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the fan drive with lock guard.
// Assumes: Short detect window and tick so lock cycles stay brief.
// Notes:   Pins are sampled on the falling edge, APB at the ready edge.
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    localparam int WIN_TICKS = 20;
    localparam int TICK      = 2;
    localparam int WIN       = WIN_TICKS * TICK;
    localparam int OFF       = WIN * fan_pkg::OFF_RATIO;
    logic             clk, rst, legA, legB, tachOut, tachEnN;
    logic             alarmOut, alarmEnN, hallP, hallM, tachWire;
    logic             alarmWire, spin, kick, err;
    logic [7:0]       halfPer;
    logic [31:0]      rd;
    fan_pkg::apbReq_t req;
    fan_pkg::apbRsp_t rsp;
    int               failures, samples_checked, cycles, seed, n, dem, mn;
    int               demTab[6]  = '{0, 1800, 2775, 3600, 3600, 3600};
    int               minTab[6]  = '{0, 3360, 3360, 3000, 3500, 0};
    logic             tiedTab[6] = '{1, 0, 0, 0, 0, 1};

    fan_lock_guard #(.DETECT_TICKS(WIN_TICKS), .TICK_CYCLES(TICK))
    fan_lock_guard_inst (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp),
        .hallPlus(hallP), .hallMinus(hallM), .bridgeLegA(legA),
        .bridgeLegB(legB), .tachIn(tachWire), .tachOut(tachOut),
        .tachOutEnN(tachEnN), .alarmIn(alarmWire), .alarmOut(alarmOut),
        .alarmOutEnN(alarmEnN));
    fan_partner fan_partner_inst (.clk(clk), .spin(spin), .kick(kick),
        .halfPer(halfPer), .tachOut(tachOut), .tachOutEnN(tachEnN),
        .alarmOut(alarmOut), .alarmOutEnN(alarmEnN), .hallPlus(hallP),
        .hallMinus(hallM), .tachWire(tachWire), .alarmWire(alarmWire));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures = failures + 1;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic checkNear(input int got, input int exp, input int tol);
        samples_checked++;
        if (got < exp - tol || got > exp + tol) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkNear
    // Entered just after a rising edge; leaves one edge after release
    // Data and error are taken at the edge that samples ready high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        req <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask : apb
    task automatic waitLegs(input logic want, output int k);
        k = 0;
        while ((legA | legB) !== want && k < 2000) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
    endtask : waitLegs
    task automatic pulse();
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
    endtask : pulse
    function automatic int permille(input int d, input int m, input logic t);
        int eff;
        eff = t ? int'(fan_pkg::MIN_TIED_MV) :
              (m < int'(fan_pkg::LOWEST_SPEED_MV) ? m : int'(fan_pkg::LOWEST_SPEED_MV));
        if (d < eff) eff = d;
        if (eff <= int'(fan_pkg::RAMP_LOW_MV)) return 1000;
        return (int'(fan_pkg::RAMP_HIGH_MV) - eff) * 1000 / int'(fan_pkg::RAMP_SPAN_MV);
    endfunction : permille
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 23122;
        rst = 1'b1;
        req = '0;
        spin = 1'b0;
        kick = 1'b0;
        halfPer = 8'h10;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, fan_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h8000_0000);
        apb(1'b0, fan_pkg::WINDOW_OFS, 32'h0);
        check(rd, 32'(WIN_TICKS));
        apb(1'b0, 8'h0C, 32'h0);
        check({31'h0, err}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            pulse();
            repeat (8) @(negedge clk);
            check({30'h0, legB, legA}, {30'h0, hallP, ~hallP});
            check({31'h0, tachWire}, {31'h0, hallP});
            @(posedge clk);
        end
        // Random rotation rates, always inside the detect window
        spin <= 1'b1;
        repeat (30) begin
            halfPer <= 8'h05 + 8'($random(seed) & 32'hF);
            repeat (25) @(negedge clk);
            check({31'h0, alarmWire}, 32'h0);
            @(posedge clk);
        end
        spin <= 1'b0;
        waitLegs(1'b0, n);
        check({31'h0, alarmWire}, 32'h1);
        waitLegs(1'b1, n);
        checkNear(n, OFF, TICK + 4);
        check({31'h0, alarmWire}, 32'h1);
        waitLegs(1'b0, n);
        checkNear(n, WIN, TICK + 4);
        apb(1'b1, fan_pkg::STATUS_OFS, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0);
        apb(1'b0, fan_pkg::STATUS_OFS, 32'h0);
        check(rd & 32'h0000_FF1F,
              {16'h0, 8'h02, 3'h0, 1'b1, hallP, hallP, 2'h1});
        waitLegs(1'b1, n);
        pulse();
        repeat (8) @(negedge clk);
        check({31'h0, alarmWire}, 32'h0);
        @(posedge clk);
        spin <= 1'b1;
        apb(1'b1, fan_pkg::WINDOW_OFS, 32'h00FF_FFFF);
        apb(1'b0, fan_pkg::WINDOW_OFS, 32'h0);
        check(rd, 32'h00FF_FFFF);
        spin <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            dem = (i < 6) ? demTab[i] : 1950 + (($random(seed) & 32'h7FFF_FFFF) % 1651);
            mn  = (i < 6) ? minTab[i] : 1950 + (($random(seed) & 32'h7FFF_FFFF) % 1651);
            apb(1'b1, fan_pkg::CTRL_OFS,
                {(i < 6) ? tiedTab[i] : 1'b0, 3'h0, 12'(mn), 4'h0, 12'(dem)});
            n = 0;
            repeat (20) @(negedge clk);
            repeat (4000) begin
                @(negedge clk);
                n += int'(legA | legB);
            end
            checkNear(n / 4, permille(dem, mn, (i < 6) && tiedTab[i]), 8);
            @(posedge clk);
        end
        summarize();
    end
endmodule : tb
